/* hw/psr_pkg.sv */
`default_nettype none
package psr_pkg;
  // register encodings {op0,op1,crn,crm,op2}
  localparam logic [15:0] ENC_CTL1  = 16'hC4C8;
  localparam logic [15:0] ENC_ICNT  = 16'hC4CA;
  localparam logic [15:0] ENC_IRLD  = 16'hC4CB;
  localparam logic [15:0] ENC_FCTL  = 16'hC4CC;
  localparam logic [15:0] ENC_EVF   = 16'hC4CD;
  localparam logic [15:0] ENC_LATF  = 16'hC4CE;
  localparam logic [15:0] ENC_SID   = 16'hC4CF;
  localparam logic [15:0] ENC_LIM   = 16'hC4D0;
  localparam logic [15:0] ENC_PTR   = 16'hC4D1;
  localparam logic [15:0] ENC_SYN   = 16'hC4D3;
  localparam logic [15:0] ENC_BID   = 16'hC4D7;
  localparam logic [15:0] ENC_CTL2  = 16'hE4C8;
  localparam logic [15:0] ENC_CTL12 = 16'hECC8;
  // field positions
  localparam int CTL_USER   = 0;
  localparam int CTL_KERN   = 1;
  localparam int LIM_EN     = 0;
  localparam int LIM_LSB    = 12;
  localparam int SYN_EC_LSB = 26;
  localparam int SYN_LOST   = 19;
  localparam int SYN_EA     = 18;
  localparam int SYN_STOP   = 17;
  localparam int BID_FLAGS  = 5;
  localparam int BID_PROHIB = 4;
  // syndrome codes and levels
  localparam logic [5:0] CLASS_OTHER = 6'h00;
  localparam logic [5:0] CLASS_S1ABT = 6'h24;
  localparam logic [5:0] BSC_NONE    = 6'h00;
  localparam logic [5:0] BSC_FULL    = 6'h01;
  localparam logic [1:0] EL_USER     = 2'h0;
  localparam logic [1:0] EL_KERN     = 2'h1;
  localparam logic [1:0] EL_HYP      = 2'h2;
  localparam logic [63:0] REG_RST    = 64'h0;
  localparam logic [63:0] WORD_BYTES = 64'h8;

  typedef struct packed {
    logic        wr;
    logic [15:0] enc;
    logic [63:0] wdata;
  } psr_sreq_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [1:0]  share;
  } psr_mreq_t;

  typedef enum logic [2:0] {
    BAR_IDLE  = 3'h1,
    BAR_DRAIN = 3'h2,
    BAR_DONE  = 3'h4
  } psr_bar_t;
endpackage
`default_nettype wire

/* hw/psr_rec_wr.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_rec_wr
  import psr_pkg::*;
#(
  parameter int WORDS = 4
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        kill,
  input  wire logic [63:0] base,
  input  wire logic [63:0] info,
  input  wire logic [1:0]  share,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output psr_mreq_t        mem_req,
  input  wire logic        resp_valid,
  input  wire logic        resp_abort,
  output logic             busy,
  output logic             idle,
  output logic             done,
  output logic [63:0]      next_ptr,
  output logic             abort,
  output logic [63:0]      abort_addr
);
  localparam int IW = $clog2(WORDS) + 1;
  localparam logic [IW-1:0] LAST = IW'(WORDS - 1);
  logic [IW-1:0] idx_r;
  logic [7:0]    outst_r;
  logic [63:0]   addr_r, data_r, raddr_r;
  logic [1:0]    share_r;
  logic          busy_r, acc;

  assign acc = busy_r & mem_ready;

  // word issue; one record at a time
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      idx_r <= '0;
      addr_r <= REG_RST;
      data_r <= REG_RST;
      share_r <= '0;
    end else if (kill) begin
      busy_r <= 1'b0;
    end else if (start & ~busy_r) begin
      busy_r <= 1'b1;
      idx_r <= '0;
      addr_r <= base;
      data_r <= info;
      share_r <= share;
    end else if (acc) begin
      busy_r <= (idx_r != LAST);
      idx_r <= idx_r + 1'b1;
      addr_r <= addr_r + WORD_BYTES;
      data_r <= 64'(idx_r + 1'b1); // word index as filler
    end
  end

  // outstanding writes; responses come back in order
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      outst_r <= '0;
      raddr_r <= REG_RST;
    end else begin
      outst_r <= outst_r + 8'(acc) - 8'(resp_valid);
      if (start & ~busy_r & (outst_r == '0)) raddr_r <= base;
      else if (resp_valid) raddr_r <= raddr_r + WORD_BYTES;
    end
  end

  assign mem_valid  = busy_r;
  assign mem_req    = '{addr: addr_r, data: data_r, share: share_r};
  assign busy       = busy_r;
  assign idle       = ~busy_r & (outst_r == '0);
  assign done       = acc & (idx_r == LAST);
  assign next_ptr   = addr_r + WORD_BYTES;
  assign abort      = resp_valid & resp_abort;
  assign abort_addr = raddr_r;
endmodule
`default_nettype wire

/* hw/psr_shadow.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_shadow
  import psr_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ctx_sync,
  input  wire logic [W-1:0] live,
  output logic      [W-1:0] view
);
  logic [W-1:0] view_r;

  // copy taken only at context sync; stale until then
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      view_r <= '0;
    end else if (ctx_sync) begin
      view_r <= live;
    end
  end

  assign view = view_r;
endmodule
`default_nettype wire

/* hw/psr_top.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_top
  import psr_pkg::*;
#(
  parameter int          REC_WORDS   = 4,
  parameter logic        EXT_PRESENT = 1'b1,
  parameter logic        FLAG_UPDATE = 1'b1,
  parameter logic [3:0]  ALIGN       = 4'h3,
  parameter logic        LOST_EVENT  = 1'b1,
  parameter logic [63:0] SAMPLE_ID   = 64'h0
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        sr_valid,
  input  wire psr_sreq_t   sr_req,
  output logic             sr_rvalid,
  output logic [63:0]      sr_rdata,
  output logic             sr_undef,
  input  wire logic [1:0]  cur_el,
  input  wire logic [1:0]  owner_el,
  input  wire logic        op_valid,
  input  wire logic [63:0] op_info,
  output logic             op_sampled,
  output logic             prof_enabled,
  input  wire logic        ctx_sync,
  input  wire logic        pbar_req,
  output logic             pbar_done,
  input  wire logic        dbar_req,
  output logic             dbar_done,
  input  wire logic        core_mem_idle,
  input  wire logic [1:0]  core_share,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output psr_mreq_t        mem_req,
  input  wire logic        mem_resp_valid,
  input  wire logic        mem_resp_abort
);
  localparam logic [63:0] REC_BYTES = 64'(REC_WORDS) * WORD_BYTES;

  logic [63:0] ctl1_r, ctl2_r, icnt_r, irld_r, fctl_r, evf_r, latf_r;
  logic [63:0] lim_r, ptr_r, syn_r, ptr_view_r, syn_view_r;
  logic [64:0] sh_live, sh_view;
  logic [63:0] bid_c, rd_c, nxt_ptr, abt_addr;
  logic        known_c, ro_c, undef_c, wr_ok;
  logic        wr_ptr, wr_syn, lvl_en, samp_en, sel;
  logic        sh_en, full_c, start_rec, ev_full, ev_lost;
  logic        wr_busy, wr_idle, wr_done, wr_abort;
  logic        csync_seen_r, ind_blk_r, abt_evt;
  psr_bar_t    bar_r;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);

  // buffer id: flags bit, prohibited bit, alignment
  function automatic logic [63:0] bid_val(input logic [1:0] cel,
                                          input logic [1:0] oel);
    bid_val = REG_RST;
    bid_val[BID_FLAGS] = FLAG_UPDATE;
    bid_val[BID_PROHIB] = (oel > cel);
    bid_val[3:0] = ALIGN;
  endfunction

  assign bid_c = bid_val(cur_el, owner_el);

  // decode; every access here is undefined at user level
  always_comb begin
    known_c = 1'b1;
    ro_c = 1'b0;
    rd_c = REG_RST;
    case (sr_req.enc)
      ENC_CTL1, ENC_CTL12: rd_c = ctl1_r;
      ENC_CTL2:  rd_c = ctl2_r;
      ENC_ICNT:  rd_c = icnt_r;
      ENC_IRLD:  rd_c = irld_r;
      ENC_FCTL:  rd_c = fctl_r;
      ENC_EVF:   rd_c = evf_r;
      ENC_LATF:  rd_c = latf_r;
      ENC_LIM:   rd_c = lim_r;
      ENC_PTR:   rd_c = ptr_view_r;
      ENC_SYN:   rd_c = syn_view_r;
      ENC_SID: begin
        rd_c = SAMPLE_ID; // arbitrary value
        ro_c = 1'b1;
      end
      ENC_BID: begin
        rd_c = bid_c;
        ro_c = 1'b1;
      end
      default: known_c = 1'b0;
    endcase
  end

  // undefined: unknown, user level, absent, or write to read-only
  assign undef_c = ~known_c | (cur_el == EL_USER) | ~EXT_PRESENT
                 | (ro_c & sr_req.wr);
  assign wr_ok  = sr_valid & sr_req.wr & ~undef_c;
  assign wr_ptr = wr_ok & (sr_req.enc == ENC_PTR);
  assign wr_syn = wr_ok & (sr_req.enc == ENC_SYN);

  // answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sr_rvalid <= 1'b0;
      sr_undef <= 1'b0;
      sr_rdata <= REG_RST;
    end else begin
      sr_rvalid <= sr_valid;
      sr_undef <= sr_valid & undef_c;
      sr_rdata <= (sr_valid & ~sr_req.wr & ~undef_c) ? rd_c : REG_RST;
    end
  end

  // plain read-write registers; enable bit cleared at reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctl1_r <= REG_RST;
      ctl2_r <= REG_RST;
      irld_r <= REG_RST;
      fctl_r <= REG_RST;
      evf_r <= REG_RST;
      latf_r <= REG_RST;
      lim_r <= REG_RST;
    end else if (wr_ok) begin
      case (sr_req.enc)
        ENC_CTL1, ENC_CTL12: ctl1_r <= sr_req.wdata;
        ENC_CTL2: ctl2_r <= sr_req.wdata;
        ENC_IRLD: irld_r <= sr_req.wdata;
        ENC_FCTL: fctl_r <= sr_req.wdata;
        ENC_EVF:  evf_r <= sr_req.wdata;
        ENC_LATF: latf_r <= sr_req.wdata;
        ENC_LIM:  lim_r <= sr_req.wdata;
        default: ;
      endcase
    end
  end

  // enables read live, as the instruction's own read
  always_comb begin
    lvl_en = 1'b0;
    case (cur_el)
      EL_USER: lvl_en = ctl1_r[CTL_USER] | ctl2_r[CTL_USER];
      EL_KERN: lvl_en = ctl1_r[CTL_KERN];
      EL_HYP:  lvl_en = ctl2_r[CTL_KERN];
      default: lvl_en = 1'b0;
    endcase
  end

  // owner below current level forces off
  assign samp_en = EXT_PRESENT & lvl_en & ~(owner_el < cur_el)
                 & lim_r[LIM_EN] & ~syn_r[SYN_STOP];
  assign prof_enabled = samp_en;
  assign sel = op_valid & samp_en & (icnt_r == REG_RST);
  assign op_sampled = sel;

  // interval counter; a software write beats the count
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      icnt_r <= REG_RST;
    end else if (wr_ok & (sr_req.enc == ENC_ICNT)) begin
      icnt_r <= sr_req.wdata;
    end else if (op_valid & samp_en) begin
      icnt_r <= (icnt_r == REG_RST) ? irld_r : icnt_r - 64'h1;
    end
  end

  // writer sees limit and stop bit only as of the last context sync
  assign sh_live = {syn_r[SYN_STOP], lim_r};

  psr_shadow #(.W(65)) u_shadow (
    .mclk     (mclk),
    .resetn   (resetn),
    .ctx_sync (ctx_sync),
    .live     (sh_live),
    .view     (sh_view)
  );

  assign sh_en  = sh_view[LIM_EN] & ~sh_view[64];
  assign full_c = (ptr_r + REC_BYTES)
                > {sh_view[63:LIM_LSB], {LIM_LSB{1'b0}}};
  // stale view says disabled: drop the record
  assign ev_lost = sel & ~sh_en & LOST_EVENT;
  assign ev_full = sel & sh_en & full_c;
  // hold records back while core traffic before a data barrier drains
  assign start_rec = sel & sh_en & ~full_c & ~wr_busy
                   & (~dbar_req | core_mem_idle);

  psr_rec_wr #(.WORDS(REC_WORDS)) u_wr (
    .mclk       (mclk),
    .resetn     (resetn),
    .start      (start_rec),
    .kill       (wr_abort),
    .base       (ptr_r),
    .info       (op_info),
    .share      (core_share),
    .mem_valid  (mem_valid),
    .mem_ready  (mem_ready),
    .mem_req    (mem_req),
    .resp_valid (mem_resp_valid),
    .resp_abort (mem_resp_abort),
    .busy       (wr_busy),
    .idle       (wr_idle),
    .done       (wr_done),
    .next_ptr   (nxt_ptr),
    .abort      (wr_abort),
    .abort_addr (abt_addr)
  );

  // first abort only; later responses of a stopped record must not move the pointer
  assign abt_evt = wr_abort & ~ind_blk_r & ~syn_r[SYN_STOP];
  // pointer: hardware updates apply unless a later direct write is protected
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ptr_r <= REG_RST;
    end else if (abt_evt) begin
      ptr_r <= abt_addr;
    end else if (wr_done & ~ind_blk_r) begin
      ptr_r <= nxt_ptr;
    end else if (wr_ptr) begin
      ptr_r <= sr_req.wdata;
    end
  end

  // syndrome: event set beats a same-cycle software write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      syn_r <= REG_RST;
    end else begin
      if (wr_syn) syn_r <= sr_req.wdata;
      if (abt_evt) begin
        syn_r[SYN_STOP] <= 1'b1;
        syn_r[SYN_EA] <= 1'b1;
        syn_r[SYN_EC_LSB +: 6] <= CLASS_S1ABT;
      end else if (ev_lost) begin
        syn_r[SYN_STOP] <= 1'b1;
        syn_r[SYN_LOST] <= 1'b1;
        syn_r[SYN_EC_LSB +: 6] <= CLASS_OTHER;
        syn_r[5:0] <= BSC_NONE;
      end else if (ev_full) begin
        syn_r[SYN_STOP] <= 1'b1;
        syn_r[SYN_EC_LSB +: 6] <= CLASS_OTHER;
        syn_r[5:0] <= BSC_FULL;
      end
    end
  end

  // read views refresh at context sync, which overrides a same-cycle own write; other own writes show at once
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ptr_view_r <= REG_RST;
      syn_view_r <= REG_RST;
    end else begin
      if (ctx_sync) ptr_view_r <= ptr_r;
      else if (wr_ptr) ptr_view_r <= sr_req.wdata;
      if (ctx_sync) syn_view_r <= syn_r;
      else if (wr_syn) syn_view_r <= sr_req.wdata;
    end
  end

  // direct write after a non-draining barrier locks out older updates
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ind_blk_r <= 1'b0;
    end else if (wr_idle) begin
      ind_blk_r <= 1'b0;
    end else if ((wr_ptr | wr_syn) & (bar_r == BAR_DONE)) begin
      ind_blk_r <= 1'b1;
    end
  end

  // remembers a context sync since the last barrier
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      csync_seen_r <= 1'b0;
    end else if (ctx_sync) begin
      csync_seen_r <= 1'b1;
    end else if (pbar_req & (bar_r == BAR_IDLE)) begin
      csync_seen_r <= 1'b0;
    end
  end

  // profiling barrier sequencing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bar_r <= BAR_IDLE;
    end else begin
      unique case (bar_r)
        BAR_IDLE: if (pbar_req) begin
          bar_r <= csync_seen_r ? BAR_DRAIN : BAR_DONE;
        end
        BAR_DRAIN: if (wr_idle) begin
          bar_r <= BAR_DONE;
        end
        BAR_DONE: begin
          bar_r <= BAR_IDLE;
        end
        default: bar_r <= BAR_IDLE;
      endcase
    end
  end

  assign pbar_done = (bar_r == BAR_DONE);
  // no record may be outstanding when a data barrier retires
  assign dbar_done = dbar_req & wr_idle & core_mem_idle;

  a_owner_gate: assert property ((owner_el < cur_el) |-> !op_sampled)
    else $error("sample taken while owner level below current");
  a_ro_write: assert property (sr_valid & sr_req.wr
    & ((sr_req.enc == ENC_BID) | (sr_req.enc == ENC_SID)) |=> sr_undef)
    else $error("write to id register not refused");
  a_bid_user: assert property (sr_valid & (cur_el == EL_USER)
    & (sr_req.enc == ENC_BID) |=> sr_rvalid & sr_undef)
    else $error("user level id read not undefined");
  a_bid_layout: assert property (sr_valid & ~sr_req.wr & (cur_el != EL_USER)
    & (sr_req.enc == ENC_BID) |=> (sr_rdata[63:6] == '0)
    & (sr_rdata[BID_FLAGS] == FLAG_UPDATE))
    else $error("buffer id layout wrong");
  a_lim_reset: assert property (@(posedge mclk) disable iff (1'b0)
    !resetn |=> !lim_r[LIM_EN])
    else $error("buffer enable not cleared by reset");
  a_dbar_wait: assert property (dbar_req & !wr_idle |-> !dbar_done)
    else $error("data barrier done with records outstanding");
  a_shadow_hold: assert property (!ctx_sync ##1 !ctx_sync
    |-> $stable(sh_view))
    else $error("writer view changed without context sync");
  a_abort_ptr: assert property (abt_evt
    |=> ptr_r == $past(abt_addr) ##0 syn_r[SYN_STOP] & syn_r[SYN_EA])
    else $error("abort did not update pointer and syndrome");
  a_pbar_fast: assert property (pbar_req & (bar_r == BAR_IDLE)
    & !csync_seen_r |=> pbar_done)
    else $error("barrier without context sync not immediate");
  a_drain_hold: assert property ((bar_r == BAR_DRAIN) & !wr_idle
    |=> !pbar_done)
    else $error("barrier done before records drained");
  a_lost_evt: assert property (ev_lost |=> syn_r[SYN_LOST]
    & (syn_r[SYN_EC_LSB +: 6] == CLASS_OTHER) & (syn_r[5:0] == BSC_NONE))
    else $error("lost record event fields wrong");
  a_core_order: assert property (start_rec |-> !dbar_req || core_mem_idle)
    else $error("record started before core traffic idle");

  c_drain: cover property ((bar_r == BAR_DRAIN) ##[1:20] pbar_done);
  c_abort: cover property (start_rec ##[1:40] wr_abort);
  c_full:  cover property (ev_full);
  c_lost:  cover property (ev_lost);
endmodule
`default_nettype wire

/* verification/psr_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_mem_model
  import psr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic mem_valid,
  input  wire logic slow,
  input  wire logic abort_en,
  output logic      mem_ready,
  output logic      mem_resp_valid,
  output logic      mem_resp_abort
);
  int   pend;
  logic ph;
  logic fire;

  // slow mode accepts and answers only every other cycle
  assign mem_ready = !slow || ph;
  assign fire = (pend > 0) && (!slow || ph);
  // abort line is meaningless outside a response, so it keeps moving there
  assign mem_resp_abort = mem_resp_valid ? abort_en : ph;

  // responses come back in acceptance order, one per accepted word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend           <= 0;
      ph             <= 1'b0;
      mem_resp_valid <= 1'b0;
    end else begin
      ph             <= ~ph;
      mem_resp_valid <= fire;
      pend           <= pend + int'(mem_valid && mem_ready) - int'(fire);
    end
  end
endmodule
`default_nettype wire

/* verification/tb_profiling_sync_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_profiling_sync_regs;
  import psr_pkg::*;
  logic mclk, resetn, sr_valid, sr_rvalid, sr_undef, op_valid, op_sampled, prof_enabled;
  logic ctx_sync, pbar_req, pbar_done, dbar_req, dbar_done, core_mem_idle;
  logic mem_valid, mem_ready, mem_resp_valid, mem_resp_abort, slow, abort_en;
  logic [1:0]  cur_el, owner_el, core_share;
  logic [63:0] sr_rdata, op_info, rd_val, rec_base;
  psr_sreq_t   sr_req;
  psr_mreq_t   mem_req;
  int          bad_count, n_tests, n_words, cyc, i;
  logic        und;
  logic [15:0] rw_enc [6] = '{ENC_CTL1, ENC_IRLD, ENC_FCTL, ENC_EVF, ENC_LATF, ENC_CTL2};

  psr_top u_dut (.mclk(mclk), .resetn(resetn), .sr_valid(sr_valid), .sr_req(sr_req),
    .sr_rvalid(sr_rvalid), .sr_rdata(sr_rdata), .sr_undef(sr_undef), .cur_el(cur_el),
    .owner_el(owner_el), .op_valid(op_valid), .op_info(op_info), .op_sampled(op_sampled),
    .prof_enabled(prof_enabled), .ctx_sync(ctx_sync), .pbar_req(pbar_req),
    .pbar_done(pbar_done), .dbar_req(dbar_req), .dbar_done(dbar_done),
    .core_mem_idle(core_mem_idle), .core_share(core_share), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_req(mem_req), .mem_resp_valid(mem_resp_valid),
    .mem_resp_abort(mem_resp_abort));

  psr_mem_model u_mem (.mclk(mclk), .resetn(resetn), .mem_valid(mem_valid), .slow(slow),
    .abort_en(abort_en), .mem_ready(mem_ready), .mem_resp_valid(mem_resp_valid),
    .mem_resp_abort(mem_resp_abort));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one access; the answer is registered on the edge that takes the request
  task automatic acc(input logic w, input logic [15:0] e, input logic [63:0] d);
    @(posedge mclk);
    sr_valid <= 1'b1;
    sr_req   <= psr_sreq_t'{w, e, d};
    @(posedge mclk);
    sr_valid <= 1'b0;
    #1;
    chk("answer strobe", 64'h1, {63'h0, sr_rvalid});
    rd_val = sr_rdata;
    und    = sr_undef;
  endtask

  task automatic pulse_sync;
    @(posedge mclk);
    ctx_sync <= 1'b1;
    @(posedge mclk);
    ctx_sync <= 1'b0;
  endtask

  task automatic pbar;
    @(posedge mclk);
    pbar_req <= 1'b1;
    @(posedge mclk);
    pbar_req <= 1'b0;
    #1;
    cyc = 0;
    while (pbar_done !== 1'b1 && cyc < 300) begin
      @(posedge mclk);
      #1;
      cyc++;
    end
  endtask

  task automatic sample(input logic [63:0] info);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_info  <= info;
    #1;
    chk("op selected", 64'h1, {63'h0, op_sampled});
    @(posedge mclk);
    op_valid <= 1'b0;
  endtask

  // every accepted record word: address steps by 8, payload, core's domain
  always @(posedge mclk) begin
    if (resetn && mem_valid && mem_ready) begin
      chk("word addr", rec_base + 64'(8 * (n_words % 4)), mem_req.addr);
      chk("word data", (n_words % 4 == 0) ? op_info : 64'(n_words % 4), mem_req.data);
      chk("word share", {62'h0, core_share}, {62'h0, mem_req.share});
      n_words++;
    end
  end

  // hang guard, well above the hundred or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results();
  end

  initial begin
    {sr_valid, op_valid, ctx_sync, pbar_req, dbar_req, slow, abort_en} = '0;
    sr_req = '0;
    op_info = 64'h0;
    cur_el = EL_KERN;
    owner_el = EL_KERN;
    core_share = 2'h2;
    core_mem_idle = 1'b1;
    resetn = 1'b0;
    rec_base = 64'h1000;
    {bad_count, n_tests, n_words} = '0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    // reset values and identification
    acc(0, ENC_LIM, 0); chk("limit reset", 64'h0, rd_val);
    acc(0, ENC_BID, 0); chk("buffer id", {58'h0, 1'h1, 1'h0, 4'h3}, rd_val);
    acc(1, ENC_SID, 64'h5); chk("id write undef", 64'h1, {63'h0, und});
    acc(1, ENC_BID, 64'h5); chk("id write undef", 64'h1, {63'h0, und});
    acc(0, 16'hC4C9, 0); chk("unknown undef", 64'h1, {63'h0, und});
    cur_el <= EL_USER;
    acc(0, ENC_BID, 0); chk("user level undef", 64'h1, {63'h0, und});
    cur_el <= EL_KERN;
    for (i = 0; i < 6; i++) begin
      acc(1, rw_enc[i], 64'hA5C3_0000_0000_0F00 + 64'(i));
      acc(0, rw_enc[i], 0); chk("rw reg", 64'hA5C3_0000_0000_0F00 + 64'(i), rd_val);
    end
    acc(1, ENC_CTL12, 64'hC); acc(0, ENC_CTL1, 0); chk("alias", 64'hC, rd_val);
    // buffer setup
    acc(1, ENC_PTR, rec_base);
    acc(1, ENC_LIM, 64'h0010_0001);
    acc(1, ENC_ICNT, 0);
    acc(1, ENC_IRLD, 0);
    acc(1, ENC_CTL1, 64'h2);
    pulse_sync();
    #1;
    chk("enabled", 64'h1, {63'h0, prof_enabled});
    owner_el <= EL_USER;
    @(posedge mclk); #1;
    chk("owner below", 64'h0, {63'h0, prof_enabled});
    owner_el <= EL_KERN;
    acc(1, ENC_CTL1, 64'h0); #1;
    chk("level off", 64'h0, {63'h0, prof_enabled});
    acc(1, ENC_CTL1, 64'h2);
    pbar();
    pbar(); chk("barrier fast", 64'h1, {63'h0, cyc == 0});
    // slow record write with a data barrier pending behind it
    slow <= 1'b1;
    sample(64'hFEED_0000_1234_5678);
    dbar_req <= 1'b1;
    @(posedge mclk); #1;
    chk("dbar busy", 64'h0, {63'h0, dbar_done});
    cyc = 0;
    while (dbar_done !== 1'b1 && cyc < 300) begin
      @(posedge mclk); #1; cyc++;
    end
    chk("words written", 64'd4, 64'(n_words));
    core_mem_idle <= 1'b0;
    @(posedge mclk); #1;
    chk("dbar core busy", 64'h0, {63'h0, dbar_done});
    core_mem_idle <= 1'b1;
    dbar_req <= 1'b0;
    slow <= 1'b0;
    acc(0, ENC_PTR, 0); chk("ptr stale", rec_base, rd_val);
    pulse_sync();
    acc(0, ENC_PTR, 0); chk("ptr synced", rec_base + 64'h20, rd_val);
    // aborted record, drained by a synchronized barrier
    rec_base = rec_base + 64'h20;
    abort_en <= 1'b1;
    sample(64'h0BAD_0000_0000_00A1);
    pulse_sync();
    pbar(); chk("barrier drain", 64'h1, {63'h0, pbar_done});
    abort_en <= 1'b0;
    pulse_sync();
    acc(0, ENC_PTR, 0); chk("abort ptr", rec_base, rd_val);
    acc(0, ENC_SYN, 0);
    chk("abort syndrome", {32'h0, CLASS_S1ABT, 26'h0006_0000},
        rd_val & 64'hFC06_0000);
    // live syndrome cleared but writer view still stopped: record dropped, lost event
    acc(1, ENC_SYN, 64'h0);
    cyc = n_words;
    sample(64'h0000_0000_0000_0010);
    pulse_sync();
    acc(0, ENC_SYN, 0); chk("lost syndrome", 64'h000A_0000, rd_val);
    chk("record dropped", 64'(cyc), 64'(n_words));
    results();
  end
endmodule
`default_nettype wire
